// ### include/cpwc_defs.svh
// Purpose: register offsets, field positions and reset values of the CRC configuration block
// Assumes: 32-bit APB data, byte addresses, one aligned word per register
// Notes: definitions only
`ifndef CPWC_DEFS_SVH
`define CPWC_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define CPWC_OFF_CTRL 8'h00
`define CPWC_OFF_WIDTH_LEN 8'h04
`define CPWC_OFF_TAPS_LOW 8'h08
`define CPWC_OFF_TAPS_HIGH 8'h0c
`define CPWC_OFF_INPUT_LO 8'h10
`define CPWC_OFF_INPUT_HI 8'h14
`define CPWC_OFF_RESULT_LO 8'h18
`define CPWC_OFF_RESULT_HI 8'h1c
`define CPWC_OFF_IRQ_STATUS 8'h20
`define CPWC_OFF_IRQ_MASK 8'h24

// ****************************************
// field positions
// ****************************************
`define CPWC_WIDTH_MSB 12
`define CPWC_WIDTH_LSB 8
`define CPWC_PLEN_MSB 4
`define CPWC_PLEN_LSB 0
`define CPWC_CTRL_RUN 0
`define CPWC_CTRL_ISEL 1
`define CPWC_CTRL_CLEAR 2
`define CPWC_CTRL_BUSY 3
`define CPWC_CTRL_FULL 4
`define CPWC_IRQ_CRC 0
`define CPWC_IRQ_OVFL 1

// ****************************************
// reset values
// ****************************************
`define CPWC_RST_HALF 16'h0000
`define CPWC_RST_LEN 5'h00
`define CPWC_RST_IRQ 2'h0

`endif

// ### include/cpwc_pkg.sv
// Purpose: shared types of the CRC configuration block
// Assumes: nothing beyond the defs header
// Notes: types only, constants live in cpwc_defs.svh
package cpwc_pkg;

    typedef enum logic [3:0] {
        REG_CTRL,
        REG_WIDTH_LEN,
        REG_TAPS_LOW,
        REG_TAPS_HIGH,
        REG_INPUT_LO,
        REG_INPUT_HI,
        REG_RESULT_LO,
        REG_RESULT_HI,
        REG_IRQ_STATUS,
        REG_IRQ_MASK,
        REG_NONE
    } cpwc_reg_t;

    typedef enum logic {
        ST_IDLE,
        ST_SHIFT
    } cpwc_state_t;

    typedef logic [4:0] cpwc_len_t;
    typedef logic [31:0] cpwc_word_t;

endpackage : cpwc_pkg

// ### verilog/cpwc_shifter.sv
// Purpose: serial CRC shifter with programmable length and taps
// Assumes: one bit per enabled cycle, msb-first feed from the caller
// Notes: the x^0 term is implicit, so bit 0 always takes the feedback
module cpwc_shifter (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic step,
    input wire logic clear,
    input wire logic bit_in,
    input wire cpwc_pkg::cpwc_word_t taps,
    input wire cpwc_pkg::cpwc_len_t len_m1,
    output cpwc_pkg::cpwc_word_t crc
);

    // ****************************************
    // feedback network
    // ****************************************
    logic feedback;
    cpwc_pkg::cpwc_word_t next_crc;

    // top stage of the configured length closes the loop
    assign feedback = bit_in ^ crc[len_m1];

    assign next_crc[0] = feedback;

    genvar n;
    generate
        for (n = 1; n < 32; n = n + 1)
        begin : g_stage
            // stages above the polynomial length stay cleared
            assign next_crc[n] = (5'(n) <= len_m1) ? (crc[n - 1] ^ (feedback & taps[n])) : 1'b0;
        end
    endgenerate

    // ****************************************
    // state
    // ****************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            crc <= 32'h0000_0000;
        else if (clear)
            crc <= 32'h0000_0000;
        else if (step)
            crc <= next_crc;
    end

endmodule : cpwc_shifter

// ### verilog/cpwc_regs.sv
// Purpose: APB register file, input/result buffers and shift control of the CRC unit
// Assumes: APB3 slave, zero wait states, 250 MHz CLK
// Notes: one data word is shifted msb first, one bit per cycle while running
//
// Local design decisions: the register offsets and the APB interface to the registers.
`include "cpwc_defs.svh"

// What this block does
// - word width comes from config bits 12..8, stored as width minus one
// - polynomial length comes from config bits 4..0, stored as length minus one
// - low tap bits 15..1 enable feedback of terms x^15 down to x^1
// - high tap bits 15..0 enable feedback of terms x^31 down to x^16
// - low tap bit 0 is not stored and always reads zero
// - config bits 15..13 and 7..5 ignore writes and read zero
// - run bit shifts while set and pauses the shifter while clear
// - with source select clear, interrupt fires only when all shifts finish
// - two-half input buffer feeds the shifter, two-half result buffer holds CRC
module cpwc_regs (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    output logic IRQ
);

    // ****************************************
    // address decode
    // ****************************************
    function automatic cpwc_pkg::cpwc_reg_t decode_addr(input logic [7:0] addr);
        cpwc_pkg::cpwc_reg_t sel;
        sel = cpwc_pkg::REG_NONE;
        case (addr)
            `CPWC_OFF_CTRL: sel = cpwc_pkg::REG_CTRL;
            `CPWC_OFF_WIDTH_LEN: sel = cpwc_pkg::REG_WIDTH_LEN;
            `CPWC_OFF_TAPS_LOW: sel = cpwc_pkg::REG_TAPS_LOW;
            `CPWC_OFF_TAPS_HIGH: sel = cpwc_pkg::REG_TAPS_HIGH;
            `CPWC_OFF_INPUT_LO: sel = cpwc_pkg::REG_INPUT_LO;
            `CPWC_OFF_INPUT_HI: sel = cpwc_pkg::REG_INPUT_HI;
            `CPWC_OFF_RESULT_LO: sel = cpwc_pkg::REG_RESULT_LO;
            `CPWC_OFF_RESULT_HI: sel = cpwc_pkg::REG_RESULT_HI;
            `CPWC_OFF_IRQ_STATUS: sel = cpwc_pkg::REG_IRQ_STATUS;
            `CPWC_OFF_IRQ_MASK: sel = cpwc_pkg::REG_IRQ_MASK;
            default: sel = cpwc_pkg::REG_NONE;
        endcase
        return sel;
    endfunction : decode_addr

    // ****************************************
    // declarations
    // ****************************************
    logic shifter_run, irq_source_select;
    cpwc_pkg::cpwc_len_t word_width_minus_one, poly_length_minus_one;
    logic [15:1] taps_low;
    logic [15:0] taps_high;
    logic [15:0] input_lo, input_hi;
    logic input_full;
    logic [15:0] result_lo, result_hi;
    logic [1:0] irq_status, irq_mask;
    cpwc_pkg::cpwc_state_t state, next_state;
    cpwc_pkg::cpwc_word_t shift_word, crc;
    logic [5:0] bits_left;
    logic word_end, word_end_idle;
    logic [31:0] prdata;
    logic pslverr;

    wire setup_phase, wr_en;
    cpwc_pkg::cpwc_reg_t rd_sel, wr_sel;
    wire wr_ctrl, wr_width_len, wr_taps_low, wr_taps_high, wr_input_lo, wr_input_hi, wr_irq_status, wr_irq_mask;
    wire crc_clear, input_accept, input_overflow, start_word, shift_step, last_bit, shift_bit, crc_event;
    wire [1:0] irq_set;
    cpwc_pkg::cpwc_word_t taps;
    logic [31:0] rd_value;

    // ****************************************
    // APB decode
    // ****************************************
    // read data is captured in the setup cycle so PRDATA is a flop and no wait state is needed
    assign setup_phase = PSEL & ~PENABLE;
    assign wr_en = PSEL & PENABLE & PWRITE;
    assign rd_sel = decode_addr(PADDR);
    assign wr_sel = decode_addr(PADDR);
    assign wr_ctrl = wr_en & (wr_sel == cpwc_pkg::REG_CTRL);
    assign wr_width_len = wr_en & (wr_sel == cpwc_pkg::REG_WIDTH_LEN);
    assign wr_taps_low = wr_en & (wr_sel == cpwc_pkg::REG_TAPS_LOW);
    assign wr_taps_high = wr_en & (wr_sel == cpwc_pkg::REG_TAPS_HIGH);
    assign wr_input_lo = wr_en & (wr_sel == cpwc_pkg::REG_INPUT_LO);
    assign wr_input_hi = wr_en & (wr_sel == cpwc_pkg::REG_INPUT_HI);
    assign wr_irq_status = wr_en & (wr_sel == cpwc_pkg::REG_IRQ_STATUS);
    assign wr_irq_mask = wr_en & (wr_sel == cpwc_pkg::REG_IRQ_MASK);
    assign PREADY = 1'b1;
    assign PRDATA = prdata;
    assign PSLVERR = pslverr;

    // ****************************************
    // configuration registers
    // ****************************************
    // unimplemented bits are simply not stored
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            word_width_minus_one <= `CPWC_RST_LEN;
            poly_length_minus_one <= `CPWC_RST_LEN;
        end
        else if (wr_width_len)
        begin
            word_width_minus_one <= PWDATA[`CPWC_WIDTH_MSB:`CPWC_WIDTH_LSB];
            poly_length_minus_one <= PWDATA[`CPWC_PLEN_MSB:`CPWC_PLEN_LSB];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            taps_low <= 15'(`CPWC_RST_HALF >> 1);
        else if (wr_taps_low)
            taps_low <= PWDATA[15:1];
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            taps_high <= `CPWC_RST_HALF;
        else if (wr_taps_high)
            taps_high <= PWDATA[15:0];
    end

    // high half maps to x^31..x^16, low half to x^15..x^1, x^0 implicit
    assign taps = {taps_high, taps_low, 1'b0};

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            shifter_run <= 1'b0;
            irq_source_select <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            shifter_run <= PWDATA[`CPWC_CTRL_RUN];
            irq_source_select <= PWDATA[`CPWC_CTRL_ISEL];
        end
    end

    assign crc_clear = wr_ctrl & PWDATA[`CPWC_CTRL_CLEAR];

    // ****************************************
    // input buffer
    // ****************************************
    // writes while a word is still pending are dropped and flagged, so data is never overwritten
    assign input_accept = ~input_full;
    assign input_overflow = (wr_input_lo | wr_input_hi) & input_full;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            input_lo <= `CPWC_RST_HALF;
            input_hi <= `CPWC_RST_HALF;
        end
        else
        begin
            if (wr_input_lo & input_accept)
                input_lo <= PWDATA[15:0];
            if (wr_input_hi & input_accept)
                input_hi <= PWDATA[15:0];
        end
    end

    // the high half commits the word to the shifter
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            input_full <= 1'b0;
        else
            input_full <= (input_full & ~start_word) | (wr_input_hi & input_accept);
    end

    // ****************************************
    // shift control
    // ****************************************
    // one idle cycle between words keeps the control simple at a small cost in throughput
    assign start_word = shifter_run & (state == cpwc_pkg::ST_IDLE) & input_full;
    assign shift_step = shifter_run & (state == cpwc_pkg::ST_SHIFT);
    assign last_bit = shift_step & (bits_left == 6'd1);
    assign shift_bit = shift_word[5'(bits_left - 6'd1)];

    always_comb
    begin
        next_state = state;
        unique case (state)
            cpwc_pkg::ST_IDLE:
            begin
                if (start_word)
                    next_state = cpwc_pkg::ST_SHIFT;
            end
            cpwc_pkg::ST_SHIFT:
            begin
                if (last_bit)
                    next_state = cpwc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            state <= cpwc_pkg::ST_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            shift_word <= 32'h0000_0000;
            bits_left <= 6'h00;
        end
        else if (start_word)
        begin
            shift_word <= {input_hi, input_lo};
            bits_left <= {1'b0, word_width_minus_one} + 6'd1;
        end
        else if (shift_step)
            bits_left <= bits_left - 6'd1;
    end

    cpwc_shifter u_shifter (
        .clk(CLK),
        .reset_n(RESET_N),
        .step(shift_step),
        .clear(crc_clear),
        .bit_in(shift_bit),
        .taps(taps),
        .len_m1(poly_length_minus_one),
        .crc(crc)
    );

    // ****************************************
    // result buffer and completion
    // ****************************************
    // result and completion flag appear on the same edge, one cycle after the last shift
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            word_end <= 1'b0;
            word_end_idle <= 1'b0;
        end
        else
        begin
            word_end <= last_bit;
            word_end_idle <= last_bit & ~input_full;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            result_lo <= `CPWC_RST_HALF;
            result_hi <= `CPWC_RST_HALF;
        end
        else if (word_end | crc_clear)
        begin
            result_lo <= crc_clear ? `CPWC_RST_HALF : crc[15:0];
            result_hi <= crc_clear ? `CPWC_RST_HALF : crc[31:16];
        end
    end

    // ****************************************
    // interrupts
    // ****************************************
    // select clear: all shifts done; select set: input buffer has drained
    assign crc_event = irq_source_select ? start_word : word_end_idle;
    assign irq_set = {input_overflow, crc_event};

    // a new event beats a write-one-clear in the same cycle
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            irq_status <= `CPWC_RST_IRQ;
        else
            irq_status <= (irq_status & ~(wr_irq_status ? PWDATA[1:0] : 2'b00)) | irq_set;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            irq_mask <= `CPWC_RST_IRQ;
        else if (wr_irq_mask)
            irq_mask <= PWDATA[1:0];
    end

    assign IRQ = |(irq_status & irq_mask);

    // ****************************************
    // read path
    // ****************************************
    assign rd_value =
        (rd_sel == cpwc_pkg::REG_CTRL) ?
            {27'h0, input_full, state == cpwc_pkg::ST_SHIFT, 1'b0, irq_source_select, shifter_run} :
        (rd_sel == cpwc_pkg::REG_WIDTH_LEN) ?
            {19'h0, word_width_minus_one, 3'h0, poly_length_minus_one} :
        (rd_sel == cpwc_pkg::REG_TAPS_LOW) ? {16'h0, taps_low, 1'b0} :
        (rd_sel == cpwc_pkg::REG_TAPS_HIGH) ? {16'h0, taps_high} :
        (rd_sel == cpwc_pkg::REG_INPUT_LO) ? {16'h0, input_lo} :
        (rd_sel == cpwc_pkg::REG_INPUT_HI) ? {16'h0, input_hi} :
        (rd_sel == cpwc_pkg::REG_RESULT_LO) ? {16'h0, result_lo} :
        (rd_sel == cpwc_pkg::REG_RESULT_HI) ? {16'h0, result_hi} :
        (rd_sel == cpwc_pkg::REG_IRQ_STATUS) ? {30'h0, irq_status} :
        (rd_sel == cpwc_pkg::REG_IRQ_MASK) ? {30'h0, irq_mask} :
        32'h0000_0000;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata <= PWRITE ? 32'h0000_0000 : rd_value;
            pslverr <= (rd_sel == cpwc_pkg::REG_NONE);
        end
    end

endmodule : cpwc_regs

// ### dv/cpwc_props.sv
// Purpose: bus-side properties of the CRC configuration registers
// Assumes: zero wait states, one clock domain, ports of cpwc_regs only
// Notes: shadow copies follow writes so read data can be predicted
`include "cpwc_defs.svh"
module cpwc_props (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    input wire logic IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // shadow registers
    // ****************************************
    logic [31:0] wl;
    logic [31:0] tl;
    logic [31:0] th;
    logic mask_any;
    logic wr_take;
    assign wr_take = PSEL && PENABLE && PWRITE;
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wl <= 32'h0;
            tl <= 32'h0;
            th <= 32'h0;
            mask_any <= 1'b0;
        end
        else if (wr_take)
        begin
            if (PADDR == `CPWC_OFF_WIDTH_LEN)
                wl <= PWDATA & 32'h1f1f;
            if (PADDR == `CPWC_OFF_TAPS_LOW)
                tl <= PWDATA & 32'hfffe;
            if (PADDR == `CPWC_OFF_TAPS_HIGH)
                th <= PWDATA & 32'hffff;
            if (PADDR == `CPWC_OFF_IRQ_MASK)
                mask_any <= |PWDATA[1:0];
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    sequence rd_setup(logic [7:0] a);
        PSEL && !PENABLE && !PWRITE && PADDR == a;
    endsequence
    sequence any_setup;
        PSEL && !PENABLE;
    endsequence
    wl_readback_a: assert property (rd_setup(`CPWC_OFF_WIDTH_LEN) |=> PRDATA == wl)
        else $error("config word read back wrong");
    wl_reserved_a: assert property (rd_setup(`CPWC_OFF_WIDTH_LEN) |=> PRDATA[15:13] == 3'h0 && PRDATA[7:5] == 3'h0)
        else $error("config reserved bits not zero");
    tl_readback_a: assert property (rd_setup(`CPWC_OFF_TAPS_LOW) |=> PRDATA == tl)
        else $error("low taps read back wrong");
    tl_bit0_a: assert property (rd_setup(`CPWC_OFF_TAPS_LOW) |=> !PRDATA[0])
        else $error("low taps bit 0 not zero");
    th_readback_a: assert property (rd_setup(`CPWC_OFF_TAPS_HIGH) |=> PRDATA == th)
        else $error("high taps read back wrong");
    irq_masked_a: assert property (IRQ |-> mask_any)
        else $error("interrupt with every mask bit clear");
    bus_error_a: assert property (any_setup ##0 PADDR > `CPWC_OFF_IRQ_MASK |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    no_wait_a: assert property (PSEL && PENABLE |-> PREADY)
        else $error("wait state inserted");
endmodule : cpwc_props

// ### dv/crc_poly_width_config_tb.sv
// Purpose: self-checking bench of the CRC configuration registers
// Assumes: APB master in the bench, bench model of the shifter
// Notes: fixed xorshift seed, reset held 16 cycles
`include "cpwc_defs.svh"
module crc_poly_width_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, rd_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_data, seed, v, d;
    int n_fail, check_count, cw[4], cp[4];
    int unsigned ct[4], m_crc, tap;
    cpwc_regs dut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .IRQ(irq));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    task automatic chk_bit(string what, logic exp, logic got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // request held until pready is seen high at a rising edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_fail++;
            results();
        end
    endtask : apb
    task automatic wr(logic [7:0] a, logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask : wr
    task automatic rd(logic [7:0] a, logic [31:0] exp, string what);
        apb(1'b0, a, 32'h0);
        chk_word(what, exp, rd_data);
    endtask : rd
    // polls the status word, bounded so a stuck shifter ends the run
    task automatic wait_done();
        int i;
        i = 0;
        do
        begin
            apb(1'b0, `CPWC_OFF_IRQ_STATUS, 32'h0);
            i++;
        end
        while (rd_data[0] !== 1'b1 && i < 100);
        if (rd_data[0] !== 1'b1)
        begin
            n_fail++;
            results();
        end
    endtask : wait_done
    // model word: lowest cw bits, msb first, feedback at bit 0 and enabled taps only
    task automatic send(int k);
        wr(`CPWC_OFF_INPUT_LO, d & 32'hffff);
        wr(`CPWC_OFF_INPUT_HI, d >> 16);
        for (int b = cw[k] - 1; b >= 0; b--)
        begin
            automatic int unsigned fb = d[b] ^ m_crc[cp[k] - 1];
            automatic int unsigned n = fb;
            for (int t = 1; t < cp[k]; t++)
                n[t] = m_crc[t - 1] ^ (fb[0] & tap[t]);
            m_crc = n;
        end
    endtask : send
    task automatic chk_result();
        rd(`CPWC_OFF_RESULT_LO, m_crc & 32'hffff, "result low");
        rd(`CPWC_OFF_RESULT_HI, m_crc >> 16, "result high");
    endtask : chk_result
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        seed = 32'h07e9;
        n_fail = 0;
        check_count = 0;
        cw = '{16, 8, 32, 5};
        cp = '{16, 8, 32, 12};
        ct = '{32'h1021, 32'h07, 32'h04c11db7, 32'h0};
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a <= 8'h24; a += 4)
            rd(a[7:0], 32'h0, "reset value");
        chk_bit("irq after reset", 1'b0, irq);
        $display("test reset done");
        repeat (8)
        begin
            v = xs();
            wr(`CPWC_OFF_WIDTH_LEN, v);
            wr(`CPWC_OFF_TAPS_LOW, ~v);
            wr(`CPWC_OFF_TAPS_HIGH, {v[15:0], v[31:16]});
            rd(`CPWC_OFF_WIDTH_LEN, v & 32'h1f1f, "width length");
            rd(`CPWC_OFF_TAPS_LOW, ~v & 32'hfffe, "taps low");
            rd(`CPWC_OFF_TAPS_HIGH, {16'h0, v[31:16]}, "taps high");
        end
        $display("test readback done");
        apb(1'b1, 8'h40, 32'hffffffff);
        chk_bit("write error", 1'b1, rd_err);
        apb(1'b0, 8'h40, 32'h0);
        chk_bit("read error", 1'b1, rd_err);
        chk_word("unmapped data", 32'h0, rd_data);
        rd(`CPWC_OFF_WIDTH_LEN, v & 32'h1f1f, "width after unmapped");
        $display("test unmapped done");
        for (int k = 0; k < 4; k++)
        begin
            if (k == 3)
                ct[k] = xs() & 32'hffe;
            tap = ct[k] & 32'hfffffffe;
            wr(`CPWC_OFF_WIDTH_LEN, ((cw[k] - 1) << 8) | (cp[k] - 1));
            wr(`CPWC_OFF_TAPS_LOW, ct[k] & 32'hffff);
            wr(`CPWC_OFF_TAPS_HIGH, ct[k] >> 16);
            wr(`CPWC_OFF_CTRL, 32'h5);
            m_crc = 0;
            for (int j = 0; j < 2; j++)
            begin
                wr(`CPWC_OFF_IRQ_MASK, j);
                d = xs();
                send(k);
                wait_done();
                chk_bit("irq masked", j[0], irq);
                chk_result();
                wr(`CPWC_OFF_IRQ_STATUS, 32'h1);
                @(negedge clk);
                chk_bit("irq cleared", 1'b0, irq);
            end
        end
        $display("test crc words done");
        wr(`CPWC_OFF_CTRL, 32'h4);
        m_crc = 0;
        wr(`CPWC_OFF_IRQ_MASK, 32'h1);
        d = xs();
        send(3);
        repeat (60) @(posedge clk);
        rd(`CPWC_OFF_IRQ_STATUS, 32'h0, "paused status");
        rd(`CPWC_OFF_CTRL, 32'h10, "paused control");
        wr(`CPWC_OFF_INPUT_HI, 32'h1);
        rd(`CPWC_OFF_IRQ_STATUS, 32'h2, "overflow status");
        chk_bit("overflow irq masked", 1'b0, irq);
        wr(`CPWC_OFF_IRQ_STATUS, 32'h2);
        wr(`CPWC_OFF_CTRL, 32'h1);
        wait_done();
        chk_bit("irq after resume", 1'b1, irq);
        chk_result();
        $display("test pause done");
        // select set: the event comes when the buffer drains, never at word end
        wr(`CPWC_OFF_IRQ_STATUS, 32'h1);
        wr(`CPWC_OFF_CTRL, 32'h3);
        d = xs();
        send(3);
        wait_done();
        wr(`CPWC_OFF_IRQ_STATUS, 32'h1);
        repeat (40) @(posedge clk);
        rd(`CPWC_OFF_IRQ_STATUS, 32'h0, "drain select status");
        chk_result();
        $display("test drain select done");
        results();
    end
endmodule : crc_poly_width_config_tb
bind cpwc_regs cpwc_props props (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .IRQ(IRQ));
